// file: pkg/ccirq_pkg.sv
package ccirq_pkg;
  // register offsets on the serial configuration port
  localparam logic [15:0] CCIRQ_IN_FLAG_OFF = 16'h0012;
  localparam logic [15:0] CCIRQ_LOOP_FLAG_OFF = 16'h0013;
  localparam logic [15:0] CCIRQ_CAL_FLAG_OFF = 16'h0014;
  localparam logic [15:0] CCIRQ_IN_MASK_OFF = 16'h0018;
  localparam logic [15:0] CCIRQ_LOOP_MASK_OFF = 16'h0019;
  localparam logic [15:0] CCIRQ_CAL_MASK_OFF = 16'h001A;
  localparam logic [15:0] CCIRQ_SOFT_RST_OFF = 16'h001C;
  localparam logic [15:0] CCIRQ_STEP_OFF = 16'h001D;
  localparam logic [15:0] CCIRQ_PWR_OFF = 16'h001E;
  localparam logic [15:0] CCIRQ_STEP_SEL_OFF = 16'h0020;
  localparam logic [15:0] CCIRQ_OE_CTRL_OFF = 16'h0022;
  // field positions
  localparam int CCIRQ_SOFT_ALL_BIT = 0;
  localparam int CCIRQ_SOFT_LOOP_LSB = 1;
  localparam int CCIRQ_STEP_UP_BIT = 0;
  localparam int CCIRQ_STEP_DOWN_BIT = 1;
  localparam int CCIRQ_PDN_BIT = 0;
  localparam int CCIRQ_HARD_BIT = 1;
  localparam int CCIRQ_SYNC_BIT = 2;
  localparam int CCIRQ_SEL_EN_BIT = 0;
  localparam int CCIRQ_SEL_REG_BIT = 1;
  localparam int CCIRQ_SEL_LOOP_LSB = 2;
  localparam int CCIRQ_OE_SEL_BIT = 0;
  localparam int CCIRQ_OE_VAL_BIT = 1;
  localparam int CCIRQ_CAL_LSB = 4;
  // reset values
  localparam logic [7:0] CCIRQ_IN_MASK_RST = 8'h00;
  localparam logic [7:0] CCIRQ_LOOP_MASK_RST = 8'h00;
  localparam logic [3:0] CCIRQ_CAL_MASK_RST = 4'h0;
  localparam logic [3:0] CCIRQ_STEP_SEL_RST = 4'h0;
  localparam logic [1:0] CCIRQ_OE_CTRL_RST = 2'h0;
  localparam logic CCIRQ_PDN_RST = 1'b0;
  // loop codes of the step target field; code 1 is reserved
  localparam logic [1:0] CCIRQ_LOOP_A = 2'h0;
  localparam logic [1:0] CCIRQ_LOOP_C = 2'h2;
  localparam logic [1:0] CCIRQ_LOOP_D = 2'h3;
  // loops that can be stepped at all (a, c, d)
  localparam logic [3:0] CCIRQ_STEP_CAPABLE = 4'hD;
  // power sequencing states, gray along run, down, wake
  typedef enum logic [1:0] {
    CCIRQ_PWR_RUN = 2'b00,
    CCIRQ_PWR_DOWN = 2'b01,
    CCIRQ_PWR_WAKE = 2'b11
  } ccirq_pwr_type;
endpackage

// file: logic/ccirq_sticky.sv
`timescale 1ns/1ps
// sticky flag bank: live status sets, a written 0 clears only while status is 0
module ccirq_sticky #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] status,
  input wire logic clr_wr,
  input wire logic [W-1:0] clr_data,
  output logic [W-1:0] flags_r
);
  logic [W-1:0] clr_ok;
  logic [W-1:0] flags_nxt;

  // a set in the clear cycle wins, so no event is lost
  assign clr_ok = {W{clr_wr}} & ~clr_data & ~status;
  assign flags_nxt = status | (flags_r & ~clr_ok);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (status != '0) |=> ((flags_r & $past(status)) == $past(status)))
    else $error("sticky flag failed to set from live status");
  flag_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    !clr_wr |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("sticky flag dropped without a clearing write");
endmodule // ccirq_sticky

// file: logic/ccirq_ctrl.sv
`timescale 1ns/1ps
module ccirq_ctrl
  import ccirq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] input_loss_status,
  input wire logic [3:0] input_freq_off_status,
  input wire logic [3:0] loop_unlock_status,
  input wire logic [3:0] loop_holdover_status,
  input wire logic [3:0] loop_cal_status,
  input wire logic [3:0] loop_step_block,
  input wire logic global_outputs_allow,
  input wire logic out_enable_pin_n,
  input wire logic divider_sync_pin_n,
  input wire logic [1:0] loop_choice_bits,
  output logic irq_out_n,
  output logic device_restart,
  output logic [3:0] loop_restart,
  output logic bandwidth_apply,
  output logic divider_apply,
  output logic hard_reset_req,
  output logic divider_sync,
  output logic power_down,
  output logic [3:0] loop_relock,
  output logic [3:0] freq_step_up,
  output logic [3:0] freq_step_down,
  output logic outputs_enable
);
  // address match, used by both the write and the read decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] in_mask_r;
  logic [7:0] loop_mask_r;
  logic [3:0] cal_mask_r;
  logic pdn_r;
  logic [3:0] step_sel_r;
  logic [1:0] oe_ctrl_r;
  logic [7:0] in_flags;
  logic [7:0] loop_flags;
  logic [3:0] cal_flags;
  logic [7:0] rdata_r;
  logic irq_n_r;
  logic dev_rst_r;
  logic [3:0] loop_rst_r;
  logic bw_apply_r;
  logic div_apply_r;
  logic hard_r;
  logic sync_r;
  logic pd_r;
  logic [3:0] relock_r;
  logic [3:0] up_r;
  logic [3:0] down_r;
  logic oe_r;
  logic [1:0] oe_pin_meta_r;
  logic [1:0] sync_pin_meta_r;
  logic [3:0] choice_meta_r;
  logic oe_pin_n_s;
  logic sync_pin_n_s;
  logic [1:0] choice_s;
  ccirq_pwr_type pwr_r;
  ccirq_pwr_type pwr_nxt;

  // pins pass two flops; only the second stage is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_pin_meta_r <= 2'h3;
      sync_pin_meta_r <= 2'h3;
      choice_meta_r <= 4'h0;
    end else begin
      oe_pin_meta_r <= {oe_pin_meta_r[0], out_enable_pin_n};
      sync_pin_meta_r <= {sync_pin_meta_r[0], divider_sync_pin_n};
      choice_meta_r <= {choice_meta_r[1:0], loop_choice_bits};
    end
  end
  assign oe_pin_n_s = oe_pin_meta_r[1];
  assign sync_pin_n_s = sync_pin_meta_r[1];
  assign choice_s = choice_meta_r[3:2];

  // write decode
  logic wr_in_mask;
  logic wr_loop_mask;
  logic wr_cal_mask;
  logic wr_soft;
  logic wr_step;
  logic wr_pwr;
  logic wr_step_sel;
  logic wr_oe;
  logic wr_in_flag;
  logic wr_loop_flag;
  logic wr_cal_flag;
  assign wr_in_mask = reg_wr_en && hit(reg_addr, CCIRQ_IN_MASK_OFF);
  assign wr_loop_mask = reg_wr_en && hit(reg_addr, CCIRQ_LOOP_MASK_OFF);
  assign wr_cal_mask = reg_wr_en && hit(reg_addr, CCIRQ_CAL_MASK_OFF);
  assign wr_soft = reg_wr_en && hit(reg_addr, CCIRQ_SOFT_RST_OFF);
  assign wr_step = reg_wr_en && hit(reg_addr, CCIRQ_STEP_OFF);
  assign wr_pwr = reg_wr_en && hit(reg_addr, CCIRQ_PWR_OFF);
  assign wr_step_sel = reg_wr_en && hit(reg_addr, CCIRQ_STEP_SEL_OFF);
  assign wr_oe = reg_wr_en && hit(reg_addr, CCIRQ_OE_CTRL_OFF);
  assign wr_in_flag = reg_wr_en && hit(reg_addr, CCIRQ_IN_FLAG_OFF);
  assign wr_loop_flag = reg_wr_en && hit(reg_addr, CCIRQ_LOOP_FLAG_OFF);
  assign wr_cal_flag = reg_wr_en && hit(reg_addr, CCIRQ_CAL_FLAG_OFF);

  // sticky flag banks, laid out as the mask registers that gate them
  ccirq_sticky #(.W(8)) u_in_flags (
    .clk(clk),
    .arst_n(arst_n),
    .status({input_freq_off_status, input_loss_status}),
    .clr_wr(wr_in_flag),
    .clr_data(reg_wdata),
    .flags_r(in_flags)
  );
  ccirq_sticky #(.W(8)) u_loop_flags (
    .clk(clk),
    .arst_n(arst_n),
    .status({loop_holdover_status, loop_unlock_status}),
    .clr_wr(wr_loop_flag),
    .clr_data(reg_wdata),
    .flags_r(loop_flags)
  );
  ccirq_sticky #(.W(4)) u_cal_flags (
    .clk(clk),
    .arst_n(arst_n),
    .status(loop_cal_status),
    .clr_wr(wr_cal_flag),
    .clr_data(reg_wdata[7:4]),
    .flags_r(cal_flags)
  );

  // read/write control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_mask_r <= CCIRQ_IN_MASK_RST;
      loop_mask_r <= CCIRQ_LOOP_MASK_RST;
      cal_mask_r <= CCIRQ_CAL_MASK_RST;
      pdn_r <= CCIRQ_PDN_RST;
      step_sel_r <= CCIRQ_STEP_SEL_RST;
      oe_ctrl_r <= CCIRQ_OE_CTRL_RST;
    end else begin
      if (wr_in_mask) in_mask_r <= reg_wdata;
      if (wr_loop_mask) loop_mask_r <= reg_wdata;
      if (wr_cal_mask) cal_mask_r <= reg_wdata[7:4];
      if (wr_pwr) pdn_r <= reg_wdata[CCIRQ_PDN_BIT];
      if (wr_step_sel) step_sel_r <= reg_wdata[3:0];
      if (wr_oe) oe_ctrl_r <= reg_wdata[1:0];
    end
  end

  // interrupt: any sticky flag whose mask bit is clear, bit for bit
  logic irq_pend;
  assign irq_pend = |(in_flags & ~in_mask_r)
    | |(loop_flags & ~loop_mask_r)
    | |(cal_flags & ~cal_mask_r);

  // step target selection; with selection off every capable loop that loop_step_block leaves free steps
  logic sel_en;
  logic sel_reg;
  logic [1:0] target_code;
  logic [3:0] target_onehot;
  logic [3:0] step_loops;
  assign sel_en = step_sel_r[CCIRQ_SEL_EN_BIT];
  assign sel_reg = sel_en && step_sel_r[CCIRQ_SEL_REG_BIT];
  assign target_code = sel_reg ? step_sel_r[CCIRQ_SEL_LOOP_LSB +: 2] : choice_s;
  // the reserved code maps to no loop rather than to loop b
  assign target_onehot = (4'h1 << target_code) & CCIRQ_STEP_CAPABLE;
  assign step_loops = (sel_en ? target_onehot : CCIRQ_STEP_CAPABLE) & ~loop_step_block;

  // strobes are written as one and read back as zero, so the write is the edge
  logic step_up_hit;
  logic step_down_hit;
  assign step_up_hit = wr_step && reg_wdata[CCIRQ_STEP_UP_BIT];
  assign step_down_hit = wr_step && reg_wdata[CCIRQ_STEP_DOWN_BIT];

  logic soft_all_hit;
  logic [3:0] soft_loop_hit;
  assign soft_all_hit = wr_soft && reg_wdata[CCIRQ_SOFT_ALL_BIT];
  assign soft_loop_hit = {4{wr_soft}} & reg_wdata[CCIRQ_SOFT_LOOP_LSB +: 4];

  // output gating; register value is active high, pin is active low
  logic oe_nxt;
  assign oe_nxt = global_outputs_allow
    && (oe_ctrl_r[CCIRQ_OE_SEL_BIT] ? oe_ctrl_r[CCIRQ_OE_VAL_BIT] : !oe_pin_n_s);

  // power sequencing: a wake state forces a fresh lock search on exit
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      CCIRQ_PWR_RUN: if (pdn_r) pwr_nxt = CCIRQ_PWR_DOWN;
      CCIRQ_PWR_DOWN: if (!pdn_r) pwr_nxt = CCIRQ_PWR_WAKE;
      CCIRQ_PWR_WAKE: pwr_nxt = CCIRQ_PWR_RUN;
      default: pwr_nxt = CCIRQ_PWR_RUN;
    endcase
  end

  // action outputs; strobes are single-cycle pulses, except divider_sync, which stays high while the sync pin is held low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r <= CCIRQ_PWR_RUN;
      irq_n_r <= 1'b1;
      dev_rst_r <= 1'b0;
      loop_rst_r <= 4'h0;
      bw_apply_r <= 1'b0;
      div_apply_r <= 1'b0;
      hard_r <= 1'b0;
      sync_r <= 1'b0;
      pd_r <= 1'b0;
      relock_r <= 4'h0;
      up_r <= 4'h0;
      down_r <= 4'h0;
      oe_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      irq_n_r <= !irq_pend;
      dev_rst_r <= soft_all_hit;
      loop_rst_r <= soft_loop_hit;
      bw_apply_r <= soft_all_hit;
      div_apply_r <= soft_all_hit;
      hard_r <= wr_pwr && reg_wdata[CCIRQ_HARD_BIT];
      // pin low and register strobe drive the same divider reset
      sync_r <= (wr_pwr && reg_wdata[CCIRQ_SYNC_BIT]) || !sync_pin_n_s;
      pd_r <= (pwr_nxt == CCIRQ_PWR_DOWN);
      relock_r <= {4{pwr_nxt == CCIRQ_PWR_WAKE}};
      up_r <= {4{step_up_hit}} & step_loops;
      down_r <= {4{step_down_hit}} & step_loops;
      oe_r <= oe_nxt;
    end
  end

  // read mux; strobe registers read zero, unmapped addresses read zero
  logic [7:0] rd_mux;
  assign rd_mux =
    hit(reg_addr, CCIRQ_IN_FLAG_OFF) ? in_flags :
    hit(reg_addr, CCIRQ_LOOP_FLAG_OFF) ? loop_flags :
    hit(reg_addr, CCIRQ_CAL_FLAG_OFF) ? {cal_flags, 4'h0} :
    hit(reg_addr, CCIRQ_IN_MASK_OFF) ? in_mask_r :
    hit(reg_addr, CCIRQ_LOOP_MASK_OFF) ? loop_mask_r :
    hit(reg_addr, CCIRQ_CAL_MASK_OFF) ? {cal_mask_r, 4'h0} :
    hit(reg_addr, CCIRQ_PWR_OFF) ? {7'h00, pdn_r} :
    hit(reg_addr, CCIRQ_STEP_SEL_OFF) ? {4'h0, step_sel_r} :
    hit(reg_addr, CCIRQ_OE_CTRL_OFF) ? {6'h00, oe_ctrl_r} : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_out_n = irq_n_r;
  assign device_restart = dev_rst_r;
  assign loop_restart = loop_rst_r;
  assign bandwidth_apply = bw_apply_r;
  assign divider_apply = div_apply_r;
  assign hard_reset_req = hard_r;
  assign divider_sync = sync_r;
  assign power_down = pd_r;
  assign loop_relock = relock_r;
  assign freq_step_up = up_r;
  assign freq_step_down = down_r;
  assign outputs_enable = oe_r;

  // checks
  in_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|(in_flags & ~in_mask_r)) |=> !irq_out_n)
    else $error("unmasked input flag did not raise interrupt");
  loop_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|(loop_flags & ~loop_mask_r) || |(cal_flags & ~cal_mask_r)) |=> !irq_out_n)
    else $error("unmasked loop flag did not raise interrupt");
  irq_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    (((in_flags & ~in_mask_r) == 8'h00) && ((loop_flags & ~loop_mask_r) == 8'h00)
      && ((cal_flags & ~cal_mask_r) == 4'h0)) |=> irq_out_n)
    else $error("interrupt asserted with all flags masked");
  soft_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    soft_all_hit |=> (device_restart && bandwidth_apply && divider_apply)
      ##1 (!device_restart || $past(soft_all_hit)))
    else $error("whole soft reset pulse wrong");
  loop_rst_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_soft |=> (loop_restart == $past(reg_wdata[4:1]))
      && (bandwidth_apply == $past(reg_wdata[CCIRQ_SOFT_ALL_BIT])))
    else $error("loop soft reset pulse wrong");
  step_a_a: assert property (@(posedge clk) disable iff (!arst_n)
    (step_up_hit && sel_reg && step_sel_r[3:2] == CCIRQ_LOOP_A && !loop_step_block[0])
      |=> freq_step_up == 4'h1 ##1 (freq_step_up == 4'h0 || $past(step_up_hit)))
    else $error("step up not delivered to loop a");
  step_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    (loop_step_block[3] || (sel_reg && step_sel_r[3:2] == 2'h1))
      |=> !freq_step_down[3] && !freq_step_up[3] && !freq_step_down[1])
    else $error("blocked or reserved loop was stepped");
  pdn_relock_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(power_down) |-> (loop_relock == 4'hF) ##1 (loop_relock == 4'h0))
    else $error("no relock after leaving power down");
  pdn_enter_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pwr && reg_wdata[CCIRQ_PDN_BIT] && pwr_r == CCIRQ_PWR_RUN) |=> ##1 power_down)
    else $error("power down not entered");
  oe_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !global_outputs_allow |=> !outputs_enable)
    else $error("outputs enabled without global allow");
  oe_reg_a: assert property (@(posedge clk) disable iff (!arst_n)
    (global_outputs_allow && oe_ctrl_r == 2'h1) |=> !outputs_enable)
    else $error("register disable did not turn outputs off");
  hard_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pwr && reg_wdata[CCIRQ_HARD_BIT]) |=> hard_reset_req ##1 !hard_reset_req || $past(wr_pwr))
    else $error("hard reset strobe wrong");
  // the reserved code must not fall through to loop b or any other loop
  step_rsv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sel_reg && step_sel_r[3:2] == 2'h1)
      |=> (freq_step_up == 4'h0) && (freq_step_down == 4'h0))
    else $error("reserved step target moved a loop");
  sync_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    !sync_pin_n_s |=> divider_sync)
    else $error("held sync pin did not reset dividers");
endmodule // ccirq_ctrl

// file: tb/tb_top.sv
`timescale 1ns/1ps
// self-checking bench: the driver queues expected results, a monitor compares them
module tb_top;
  import ccirq_pkg::*;
  typedef struct {int due; int sel; logic [7:0] val;} ccirq_note_type;
  logic clk, arst_n, reg_wr_en, reg_rd_en, global_outputs_allow, out_enable_pin_n;
  logic divider_sync_pin_n, irq_out_n, device_restart, bandwidth_apply, divider_apply;
  logic hard_reset_req, divider_sync, power_down, outputs_enable;
  logic [15:0] reg_addr, ma, fa;
  logic [7:0] reg_wdata, reg_rdata, e;
  logic [19:0] stat;
  logic [3:0] loop_step_block, loop_restart, loop_relock, freq_step_up, freq_step_down, sv, ev;
  logic [1:0] loop_choice_bits;
  ccirq_note_type q[$];
  ccirq_note_type n;
  int cyc, tmo, error_cnt, checks_done, idx, dir;
  logic [31:0] rs;
  string nm[7] = '{"reg_rdata", "irq_out_n", "ctrl_pulses", "loop_restart",
    "freq_step_up", "freq_step_down", "loop_relock"};

  ccirq_ctrl uut (.clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .input_loss_status(stat[3:0]), .input_freq_off_status(stat[7:4]),
    .loop_unlock_status(stat[11:8]), .loop_holdover_status(stat[15:12]),
    .loop_cal_status(stat[19:16]), .loop_step_block(loop_step_block),
    .global_outputs_allow(global_outputs_allow), .out_enable_pin_n(out_enable_pin_n),
    .divider_sync_pin_n(divider_sync_pin_n), .loop_choice_bits(loop_choice_bits),
    .irq_out_n(irq_out_n), .device_restart(device_restart), .loop_restart(loop_restart),
    .bandwidth_apply(bandwidth_apply), .divider_apply(divider_apply),
    .hard_reset_req(hard_reset_req), .divider_sync(divider_sync), .power_down(power_down),
    .loop_relock(loop_relock), .freq_step_up(freq_step_up), .freq_step_down(freq_step_down),
    .outputs_enable(outputs_enable));

  // clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cycle count for due times, and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // one observed value per note kind; ctrl pulses packed: dev bw div hard sync pdn oe
  function automatic logic [7:0] outv(int s);
    case (s)
      0: return reg_rdata;
      1: return {7'h00, irq_out_n};
      2: return {1'b0, device_restart, bandwidth_apply, divider_apply, hard_reset_req,
        divider_sync, power_down, outputs_enable};
      3: return {4'h0, loop_restart};
      4: return {4'h0, freq_step_up};
      5: return {4'h0, freq_step_down};
      default: return {4'h0, loop_relock};
    endcase
  endfunction

  task automatic cmp(int s, logic [7:0] ex, logic [7:0] got);
    checks_done++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm[s], ex, got);
    end
  endtask

  // monitor: outputs only move at posedge, so the falling edge sees them settled
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      cmp(n.sel, n.val, outv(n.sel));
    end
  end

  task automatic expect_at(int s, logic [7:0] v, int d);
    q.push_back('{cyc + d, s, v});
  endtask

  // strobes are raised for one cycle and dropped a full cycle apart
  task automatic wr(logic [15:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] ex);
    reg_addr = a;
    reg_rd_en = 1'b1;
    expect_at(0, ex, 1);
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [3:0] tgt(logic [1:0] c);
    return (c == 2'h0) ? 4'h1 : (c == 2'h2) ? 4'h4 : (c == 2'h3) ? 4'h8 : 4'h0;
  endfunction

  initial begin
    {cyc, tmo, error_cnt, checks_done} = '0;
    rs = 32'd34;
    {arst_n, reg_wr_en, reg_rd_en, global_outputs_allow} = '0;
    {out_enable_pin_n, divider_sync_pin_n} = 2'b11;
    {reg_addr, reg_wdata, stat, loop_step_block, loop_choice_bits} = '0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    // reset values, and an unmapped place read 0 even after a write
    expect_at(1, 8'h01, 1);
    rd(16'h0019, 8'h00);
    rd(16'h0020, 8'h00);
    rd(16'h0018, 8'h00);
    rd(16'h001A, 8'h00);
    rd(16'h0022, 8'h00);
    rd(16'h001E, 8'h00);
    wr(16'h0021, 8'hFF);
    rd(16'h0021, 8'h00);
    $display("test reset done");
    // mask registers hold random values; calibration mask keeps only 7:4
    for (int g = 0; g < 3; g++) begin
      e = 8'(xs());
      ma = 16'(CCIRQ_IN_MASK_OFF + g);
      wr(ma, e);
      rd(ma, (g == 2) ? (e & 8'hF0) : e);
    end
    // each flag alone: masked, held by live status, unmasked, cleared
    for (int g = 0; g < 3; g++) begin
      ma = 16'(CCIRQ_IN_MASK_OFF + g);
      fa = 16'(CCIRQ_IN_FLAG_OFF + g);
      for (int b = (g == 2) ? 4 : 0; b < 8; b++) begin
        idx = (g == 2) ? 12 + b : g * 8 + b;
        wr(ma, 8'h01 << b);
        stat[idx] = 1'b1;
        repeat (3) @(negedge clk);
        expect_at(1, 8'h01, 1);
        wr(fa, 8'h00);
        rd(fa, 8'h01 << b);
        stat[idx] = 1'b0;
        expect_at(1, 8'h00, 2);
        wr(ma, 8'h00);
        expect_at(1, 8'h01, 2);
        wr(fa, 8'h00);
        rd(fa, 8'h00);
      end
    end
    $display("test interrupt masks done");
    // soft reset strobes, then per-loop restarts without bandwidth apply
    expect_at(2, 8'h70, 1);
    expect_at(2, 8'h00, 2);
    wr(CCIRQ_SOFT_RST_OFF, 8'h01);
    for (int i = 0; i < 4; i++) begin
      expect_at(3, 8'h01 << i, 1);
      expect_at(2, 8'h00, 1);
      expect_at(3, 8'h00, 2);
      wr(CCIRQ_SOFT_RST_OFF, 8'h02 << i);
      // bandwidth apply of a restarted loop sits outside this block and must not touch it
      expect_at(2, 8'h00, 1);
      wr((i == 3) ? 16'h0715 : 16'(16'h0414 + 16'h0100 * i), 8'h01);
    end
    expect_at(2, 8'h00, 1);
    wr(CCIRQ_SOFT_RST_OFF, 8'h00);
    rd(CCIRQ_SOFT_RST_OFF, 8'h00);
    $display("test soft reset done");
    // stepping: selection off, register field, pin field, with random blocking
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 4; c++) begin
        sv = (m == 0) ? {2'(c), 2'b10} : (m == 1) ? {2'(c), 2'b11} : {~2'(c), 2'b01};
        loop_choice_bits = 2'(c);
        e = 8'(xs());
        loop_step_block = e[3:0];
        dir = e[4];
        wr(CCIRQ_STEP_SEL_OFF, {4'h0, sv});
        rd(CCIRQ_STEP_SEL_OFF, {4'h0, sv});
        ev = ((m == 0) ? 4'hD : tgt(2'(c))) & ~e[3:0];
        expect_at(4 + dir, {4'h0, ev}, 1);
        expect_at(4 + dir, 8'h00, 2);
        wr(CCIRQ_STEP_OFF, dir ? 8'h02 : 8'h01);
      end
    end
    $display("test stepping done");
    // power down and wake, hard reset, sync by register and by pin
    expect_at(2, 8'h02, 2);
    wr(CCIRQ_PWR_OFF, 8'h01);
    rd(CCIRQ_PWR_OFF, 8'h01);
    expect_at(6, 8'h0F, 2);
    expect_at(2, 8'h00, 2);
    expect_at(6, 8'h00, 3);
    wr(CCIRQ_PWR_OFF, 8'h00);
    expect_at(2, 8'h08, 1);
    expect_at(2, 8'h00, 2);
    wr(CCIRQ_PWR_OFF, 8'h02);
    expect_at(2, 8'h04, 1);
    expect_at(2, 8'h00, 2);
    wr(CCIRQ_PWR_OFF, 8'h04);
    divider_sync_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    expect_at(2, 8'h04, 1);
    divider_sync_pin_n = 1'b1;
    repeat (5) @(negedge clk);
    $display("test power and sync done");
    // output enable: every combination of allow, pin, source and value
    for (int i = 0; i < 16; i++) begin
      global_outputs_allow = i[3];
      out_enable_pin_n = i[2];
      wr(CCIRQ_OE_CTRL_OFF, {6'h00, i[0], i[1]});
      repeat (3) @(negedge clk);
      expect_at(2, {7'h00, i[3] & (i[1] ? i[0] : ~i[2])}, 1);
      @(negedge clk);
    end
    $display("test output enable done");
    repeat (4) @(negedge clk);
    give_verdict();
  end
endmodule // tb_top
